// File: rtl/mdap_host.sv
// host controller driving a 65,536 x 1 multiplexed dram through its strobes
// assumes one request at a time; read data arrive on the data output pin
`timescale 1ns/1ps
`default_nettype none
module mdap_host
    import mdap_pkg::*;
#(
    parameter int POWERUP_CYCLES = mdap_pkg::POWERUP_CYC,
    parameter int REFRESH_SLOT   = mdap_pkg::REFRESH_SLOT_CYC
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_b,
    input  wire logic                        req_valid,
    input  wire mdap_pkg::mdap_op_type       req_op,
    input  wire logic [mdap_pkg::ADDR_W-1:0] req_addr,
    input  wire logic                        req_wdata,
    input  wire logic                        self_exit,
    output var  logic                        req_ready,
    output var  logic                        rsp_valid,
    output var  logic                        rsp_rdata,
    output var  logic                        init_done,
    output var  logic                        ras_b,
    output var  logic                        cas_b,
    output var  logic                        we_b,
    output var  logic                        refresh_b,
    output var  logic [mdap_pkg::MUX_W-1:0]  multiplexed_address,
    output var  logic                        dram_din,
    input  wire logic                        dram_dout
);
    import mdap_pkg::*;

    // ==========================================================
    // state and counters
    mdap_state_type                 state_r, state_nxt;
    logic [CNT_W-1:0]               cnt_r, cnt_nxt;
    logic [CNT_W-1:0]               ref_cnt_r;
    logic                           ref_due_r;
    logic [3:0]                     init_cnt_r;
    logic [REFRESH_ROW_W-1:0]       ref_row_r;
    mdap_op_type                    op_r;
    logic [ADDR_W-1:0]              addr_r;
    logic                           wdata_r;
    logic                           dout_s;

    mdap_sync u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d_async (dram_dout),
        .q_sync  (dout_s)
    );

    // ==========================================================
    // decode
    wire cnt_done   = (cnt_r == '0);
    wire is_write   = (op_r == MDAP_OP_WRITE);
    wire is_rmw     = (op_r == MDAP_OP_RMW);
    wire take_req   = (state_r == MDAP_ST_IDLE) && !ref_due_r && req_valid;
    wire start_ref  = (state_r == MDAP_ST_IDLE) && ref_due_r;
    wire ref_tick   = (ref_cnt_r == CNT_W'(REFRESH_SLOT - 1));
    wire ref_served = (state_r == MDAP_ST_REFRAS) && cnt_done;
    // reads sample three cycles past access time: one of pin margin, two for the synchroniser
    wire rd_sample  = (state_r == MDAP_ST_ACCESS) && cnt_done && !is_write;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n - 1);
    endfunction : cyc

    // ==========================================================
    // sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_done ? cnt_r : cnt_r - 1'b1;
        case (state_r)
            MDAP_ST_POWERUP: if (cnt_done) begin
                state_nxt = MDAP_ST_INIT;
                cnt_nxt   = cyc(RAS_PULSE_CYC);
            end
            MDAP_ST_INIT: if (cnt_done) begin
                state_nxt = MDAP_ST_PRECH;
                cnt_nxt   = cyc(PRECHARGE_CYC);
            end
            MDAP_ST_IDLE: if (start_ref) begin
                state_nxt = MDAP_ST_REFRAS;
                cnt_nxt   = cyc(RAS_PULSE_CYC);
            end else if (take_req && req_op == MDAP_OP_SELF) begin
                state_nxt = MDAP_ST_SELF;
                cnt_nxt   = cyc(FLAG_SETUP_CYC);
            end else if (take_req) begin
                state_nxt = MDAP_ST_ROW;
                cnt_nxt   = cyc(RCD_CYC);
            end
            MDAP_ST_ROW: if (cnt_done) begin
                state_nxt = MDAP_ST_COL;
                cnt_nxt   = '0;
            end
            MDAP_ST_COL: begin
                state_nxt = MDAP_ST_ACCESS;
                cnt_nxt   = cyc(CAC_CYC + 3);
            end
            MDAP_ST_ACCESS: if (cnt_done) begin
                state_nxt = is_rmw ? MDAP_ST_WPULSE : MDAP_ST_HOLD;
                cnt_nxt   = is_rmw ? cyc(WP_CYC) : cyc(RRH_CYC);
            end
            MDAP_ST_WPULSE: if (cnt_done) begin
                state_nxt = MDAP_ST_HOLD;
                cnt_nxt   = cyc(RRH_CYC);
            end
            MDAP_ST_HOLD: if (cnt_done) begin
                state_nxt = MDAP_ST_PRECH;
                cnt_nxt   = cyc(PRECHARGE_CYC);
            end
            MDAP_ST_PRECH: if (cnt_done) begin
                state_nxt = (init_cnt_r < 4'(INIT_STROBES)) ? MDAP_ST_INIT : MDAP_ST_IDLE;
                cnt_nxt   = cyc(RAS_PULSE_CYC);
            end
            MDAP_ST_REFRAS: if (cnt_done) begin
                state_nxt = MDAP_ST_PRECH;
                cnt_nxt   = cyc(PRECHARGE_CYC);
            end
            MDAP_ST_SELF: if (cnt_done && self_exit) begin
                state_nxt = MDAP_ST_SEXIT;
                cnt_nxt   = cyc(SELF_EXIT_CYC);
            end
            MDAP_ST_SEXIT: if (cnt_done) begin
                state_nxt = MDAP_ST_PRECH;
                cnt_nxt   = cyc(PRECHARGE_CYC);
            end
            default: begin
                state_nxt = MDAP_ST_IDLE;
                cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= MDAP_ST_POWERUP;
            cnt_r   <= CNT_W'(POWERUP_CYCLES - 1);
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // ==========================================================
    // init strobes and refresh budget
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            init_cnt_r <= 4'h0;
        end else if (state_r == MDAP_ST_INIT && cnt_done) begin
            init_cnt_r <= init_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ref_cnt_r <= '0;
            ref_due_r <= 1'b0;
            ref_row_r <= '0;
        end else begin
            ref_cnt_r <= ref_tick ? '0 : ref_cnt_r + 1'b1;
            // new tick wins over the serviced clear
            if (ref_tick) begin
                ref_due_r <= 1'b1;
            end else if (ref_served) begin
                ref_due_r <= 1'b0;
            end
            if (ref_served) begin
                ref_row_r <= ref_row_r + 1'b1;
            end
        end
    end

    // ==========================================================
    // request capture
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            op_r    <= MDAP_OP_READ;
            addr_r  <= '0;
            wdata_r <= 1'b0;
        end else if (take_req) begin
            op_r    <= req_op;
            addr_r  <= req_addr;
            wdata_r <= req_wdata;
        end
    end

    // ==========================================================
    // pin drive, all registered
    wire ras_low = (state_r == MDAP_ST_INIT) || (state_r == MDAP_ST_ROW) ||
                   (state_r == MDAP_ST_COL) || (state_r == MDAP_ST_ACCESS) ||
                   (state_r == MDAP_ST_WPULSE) || (state_r == MDAP_ST_HOLD) ||
                   (state_r == MDAP_ST_REFRAS);
    // column strobe rises with the hold phase, row stays low for its hold
    wire cas_low = (state_r == MDAP_ST_COL) || (state_r == MDAP_ST_ACCESS) ||
                   (state_r == MDAP_ST_WPULSE);
    // early write: write strobe low before the column falls
    wire we_low  = ((state_r == MDAP_ST_ROW || cas_low) && is_write) ||
                   (state_r == MDAP_ST_WPULSE);
    wire col_ph  = (state_r == MDAP_ST_COL) || (state_r == MDAP_ST_ACCESS) ||
                   (state_r == MDAP_ST_WPULSE) || (state_r == MDAP_ST_HOLD);
    wire [MUX_W-1:0] addr_nxt =
        (state_r == MDAP_ST_REFRAS || state_r == MDAP_ST_INIT) ?
            {1'b0, ref_row_r} :
        col_ph ? addr_r[ADDR_W-1:MUX_W] : addr_r[MUX_W-1:0];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ras_b               <= STROBE_IDLE;
            cas_b               <= STROBE_IDLE;
            we_b                <= STROBE_IDLE;
            refresh_b           <= STROBE_IDLE;
            multiplexed_address <= '0;
            dram_din            <= 1'b0;
        end else begin
            ras_b               <= !ras_low;
            cas_b               <= !cas_low;
            we_b                <= !we_low;
            // held steady in self refresh, never pulsed, so the auto period window is unused
            refresh_b           <= !(state_r == MDAP_ST_SELF);
            multiplexed_address <= addr_nxt;
            // separate data pins, so delayed writes need no shared line
            dram_din            <= wdata_r;
        end
    end

    // ==========================================================
    // handshake and read return
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 1'b0;
            init_done <= 1'b0;
        end else begin
            req_ready <= (state_nxt == MDAP_ST_IDLE) && !ref_due_r && !ref_tick;
            rsp_valid <= rd_sample;
            if (rd_sample) begin
                rsp_rdata <= dout_s;
            end
            init_done <= (init_cnt_r >= 4'(INIT_STROBES));
        end
    end
endmodule : mdap_host
`default_nettype wire

// File: shared/mdap_pkg.sv
// constants for the multiplexed dram host controller
// assumes a 40 MHz system clock; timing from the faster speed grade
package mdap_pkg;
    // ==========================================================
    // clock
    localparam int CLK_PERIOD_PS     = 25000;
    // ==========================================================
    // array geometry
    localparam int ADDR_W            = 16;
    localparam int MUX_W             = 8;
    localparam int REFRESH_ROWS      = 128;
    localparam int REFRESH_ROW_W     = 7;
    localparam int INIT_STROBES      = 8;
    // ==========================================================
    // times in their own units
    localparam int POWERUP_US        = 100;
    localparam int REFRESH_PERIOD_MS = 2;
    localparam int RAS_PULSE_NS      = 150;
    localparam int RAS_PRECHARGE_NS  = 120;
    localparam int RCD_MIN_NS        = 30;
    localparam int CAS_PULSE_NS      = 75;
    localparam int CAC_NS            = 75;
    localparam int WRITE_PULSE_NS    = 45;
    localparam int RRH_NS            = 30;
    localparam int FLAG_PERIOD_MIN_NS = 60;
    localparam int FLAG_PERIOD_MAX_NS = 2000;
    localparam int FLAG_SETUP_NS     = 30;
    localparam int SELF_EXIT_NS      = 390;
    // ==========================================================
    // cycle counts: least times round up
    localparam int POWERUP_CYC  = (POWERUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // longest refresh interval rounds down, one row slot each
    localparam int REFRESH_SLOT_CYC =
        (REFRESH_PERIOD_MS * 1000000000 / CLK_PERIOD_PS) / REFRESH_ROWS;
    localparam int RAS_PULSE_CYC = (RAS_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PRECHARGE_CYC = (RAS_PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RCD_CYC       = (RCD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CAS_PULSE_CYC = (CAS_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CAC_CYC       = (CAC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WP_CYC        = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RRH_CYC       = (RRH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FLAG_SETUP_CYC = (FLAG_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SELF_EXIT_CYC = (SELF_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W         = 20;
    // ==========================================================
    // reset values of pins (strobes idle high)
    localparam logic STROBE_IDLE = 1'b1;
    // ==========================================================
    // request kinds and sequencer states
    typedef enum logic [1:0] {
        MDAP_OP_READ  = 2'b00,
        MDAP_OP_WRITE = 2'b01,
        MDAP_OP_RMW   = 2'b10,
        MDAP_OP_SELF  = 2'b11
    } mdap_op_type;
    typedef enum logic [3:0] {
        MDAP_ST_POWERUP = 4'b0000,
        MDAP_ST_INIT    = 4'b0001,
        MDAP_ST_IDLE    = 4'b0010,
        MDAP_ST_ROW     = 4'b0011,
        MDAP_ST_COL     = 4'b0100,
        MDAP_ST_ACCESS  = 4'b0101,
        MDAP_ST_WPULSE  = 4'b0110,
        MDAP_ST_HOLD    = 4'b0111,
        MDAP_ST_PRECH   = 4'b1000,
        MDAP_ST_REFRAS  = 4'b1001,
        MDAP_ST_SELF    = 4'b1010,
        MDAP_ST_SEXIT   = 4'b1011
    } mdap_state_type;
endpackage : mdap_pkg

// File: rtl/mdap_sync.sv
// two-flop synchroniser for the data output pin
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module mdap_sync (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic d_async,
    output var  logic q_sync
);
    logic meta_r;
    // ==========================================================
    // first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            q_sync <= 1'b0;
        end else begin
            meta_r <= d_async;
            q_sync <= meta_r;
        end
    end
endmodule : mdap_sync
`default_nettype wire

// File: sim/mdap_dram_model.sv
// behavioural model of the multiplexed 64k x 1 dram on the host's pins
// assumes strobes come from registered outputs; samples 1 ns after each falling edge
`timescale 1ns/1ps
`default_nettype none
module mdap_dram_model #(
    parameter int ACC_NS = 75
) (
    input  wire logic       ras_b,
    input  wire logic       cas_b,
    input  wire logic       we_b,
    input  wire logic       refresh_b,
    input  wire logic [7:0] multiplexed_address,
    input  wire logic       din,
    output var  logic       dout
);
    // ==========================================================
    // array and latches
    logic       cells   [0:65535];
    logic [7:0] row_r;
    logic [7:0] col_r;
    logic       early_r = 1'b0;
    logic       drive_r = 1'b0;
    logic       q_r     = 1'b0;
    function automatic logic flip(input logic [7:0] r, input logic [7:0] c);
        return r[0] == c[1];
    endfunction : flip
    // released pin shows the inverse bit, so a stale value never passes
    assign dout = drive_r ? q_r : ~q_r;
    // ==========================================================
    // strobe handling; refresh rows just latch, cells never decay here
    always @(negedge ras_b) begin
        #1 row_r = multiplexed_address;
    end
    always @(negedge cas_b) begin
        #1;
        if (!ras_b) begin
            col_r = multiplexed_address;
            early_r = !we_b;
            q_r = cells[{col_r, row_r}] ^ flip(row_r, col_r);
            if (early_r) cells[{col_r, row_r}] = din ^ flip(row_r, col_r);
            #(ACC_NS) drive_r = !cas_b && !early_r;
        end
    end
    always @(posedge cas_b) drive_r = 1'b0;
    always @(negedge we_b) begin
        #1;
        if (!cas_b && !ras_b) cells[{col_r, row_r}] = din ^ flip(row_r, col_r);
    end
endmodule : mdap_dram_model
`default_nettype wire

// File: sim/mdap_host_monitor.sv
// strobe timing checker for the dram host controller
// bound onto mdap_host; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module mdap_host_monitor #(
    parameter int POWERUP_CYCLES = 20,
    parameter int REFRESH_SLOT   = 200
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic init_done,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic refresh_b
);
    // ==========================================================
    // helper counters
    logic [19:0] pwr_cnt_r;
    logic [3:0]  falls_r;
    logic [15:0] gap_r;
    logic        ras_d_r;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pwr_cnt_r <= 20'h0;
            falls_r   <= 4'h0;
            gap_r     <= 16'h0;
            ras_d_r   <= 1'b1;
        end else begin
            ras_d_r <= ras_b;
            if (pwr_cnt_r < 20'(POWERUP_CYCLES)) pwr_cnt_r <= pwr_cnt_r + 20'h1;
            if (!init_done && ras_d_r && !ras_b) falls_r <= falls_r + 4'h1;
            gap_r <= (ras_b && refresh_b) ? gap_r + 16'h1 : 16'h0;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_ras_held;  !ras_b [*6];             endsequence
    sequence s_precharge; ras_b [*5];              endsequence
    sequence s_col_wait;  cas_b [*2];              endsequence
    sequence s_col_held;  (!cas_b && !ras_b) [*3]; endsequence
    sequence s_self_quiet; ras_b [*8] ##1 ras_b [*8]; endsequence
    sequence s_we_high;   we_b ##1 we_b;           endsequence
    AST_RAS_PULSE: assert property ($fell(ras_b) |-> s_ras_held)
        else $error("row strobe pulse too short");
    AST_PRECHARGE: assert property ($rose(ras_b) |-> s_precharge)
        else $error("row precharge too short");
    AST_ROW_BEFORE_COL: assert property ($fell(ras_b) |-> s_col_wait)
        else $error("column strobe too soon after row strobe");
    AST_COL_ACCESS: assert property ($fell(cas_b) |-> s_col_held)
        else $error("column strobe released before access time");
    AST_COL_IN_ROW: assert property (!cas_b |-> !ras_b)
        else $error("column strobe low outside a row cycle");
    AST_POWERUP_QUIET: assert property (pwr_cnt_r < 20'(POWERUP_CYCLES - 1) |-> ras_b)
        else $error("row strobe during power-up pause");
    AST_INIT_COUNT: assert property ($rose(init_done) |-> falls_r == 4'h8)
        else $error("wrong count of start-up row cycles");
    AST_NO_REQ_IN_INIT: assert property (!init_done |-> !req_ready)
        else $error("ready before start-up finished");
    AST_REFRESH_GAP: assert property (init_done |-> gap_r < 16'(REFRESH_SLOT + 40))
        else $error("refresh slot missed");
    AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    AST_SELF_EXIT_WAIT: assert property ($rose(refresh_b) |-> s_self_quiet)
        else $error("row strobe too soon after self refresh release");
    AST_WE_AT_RAS_RISE: assert property ($rose(ras_b) |-> s_we_high)
        else $error("write strobe low around row strobe rise");
endmodule : mdap_host_monitor
bind mdap_host mdap_host_monitor #(
    .POWERUP_CYCLES(POWERUP_CYCLES),
    .REFRESH_SLOT  (REFRESH_SLOT)
) mdap_host_monitor_inst (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .init_done(init_done),
    .ras_b    (ras_b),
    .cas_b    (cas_b),
    .we_b     (we_b),
    .refresh_b(refresh_b)
);
`default_nettype wire

// File: sim/mdap_host_tb_top.sv
// self-checking bench for the dram host controller against a dram model
// assumes shortened power-up and refresh slot parameters
`timescale 1ns/1ps
`default_nettype none
module mdap_host_tb_top;
    import mdap_pkg::*;
    localparam int PWR  = 20;
    localparam int SLOT = 200;
    logic        clk_sys, rst_b, req_valid, req_wdata, self_exit, req_ready, rsp_valid;
    logic        rsp_rdata, init_done, ras_b, cas_b, we_b, refresh_b, dram_din, dram_dout;
    logic        ras_q, saw_self;
    mdap_op_type req_op;
    logic [15:0] req_addr;
    logic [7:0]  multiplexed_address;
    int          n_errors, comparisons, seed, cyc, r;
    logic        shadow    [logic [15:0]];
    logic [15:0] pool      [12];
    logic        rows_seen [128];
    mdap_host #(.POWERUP_CYCLES(PWR), .REFRESH_SLOT(SLOT)) mdap_host_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .self_exit(self_exit),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .init_done(init_done), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
        .refresh_b(refresh_b), .multiplexed_address(multiplexed_address),
        .dram_din(dram_din), .dram_dout(dram_dout));
    mdap_dram_model mdap_dram_model_inst (
        .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .refresh_b(refresh_b),
        .multiplexed_address(multiplexed_address), .din(dram_din), .dout(dram_dout));
    // ==========================================================
    // checking helpers
    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    task automatic check_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    function automatic logic stored_form(input logic [15:0] a, input logic d);
        return d ^ (a[0] == a[9]);
    endfunction : stored_form
    task automatic wait_ready;
        int n;
        n = 0;
        do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 3000);
        if (n >= 3000) check_bit("req_ready", 1'b1, req_ready);
    endtask : wait_ready
    // holds the request until the edge that takes it, then waits the answer
    task automatic access(input mdap_op_type op, input logic [15:0] a, input logic d);
        logic rd;
        int   n;
        n = 0;
        @(posedge clk_sys);
        #1;
        req_valid = 1'b1;
        req_op    = op;
        req_addr  = a;
        req_wdata = d;
        wait_ready();
        #1;
        req_valid = 1'b0;
        // self refresh holds until self_exit; no cell changes, no answer
        if (op == MDAP_OP_SELF) return;
        if (op == MDAP_OP_READ || op == MDAP_OP_RMW) begin
            do @(posedge clk_sys); while (rsp_valid !== 1'b1 && ++n < 200);
            rd = rsp_rdata;
            check_bit("read bit", shadow[a], rd);
        end
        if (op != MDAP_OP_READ) shadow[a] = d;
        wait_ready();
        check_bit("stored cell", stored_form(a, shadow[a]), mdap_dram_model_inst.cells[a]);
    endtask : access
    // ==========================================================
    // clock, watchers, timeout
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        ras_q <= ras_b;
        if (ras_q === 1'b1 && ras_b === 1'b0 && cas_b === 1'b1) rows_seen[multiplexed_address[6:0]] = 1'b1;
        if (refresh_b === 1'b0) saw_self = 1'b1;
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            complete_run();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        seed = 53821;
        n_errors = 0;
        comparisons = 0;
        cyc = 0;
        saw_self = 1'b0;
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_op = MDAP_OP_READ;
        req_addr = 16'h0000;
        req_wdata = 1'b0;
        self_exit = 1'b0;
        foreach (rows_seen[i]) rows_seen[i] = 1'b0;
        pool = '{16'h0000, 16'hffff, 16'h0201, 16'h0200, 16'h0001, 16'hfdfe, 0, 0, 0, 0, 0, 0};
        for (int i = 6; i < 12; i++) pool[i] = 16'($random(seed));
        repeat (12) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        wait_ready();
        check_bit("init_done", 1'b1, init_done);
        foreach (pool[i]) access(MDAP_OP_WRITE, pool[i], 1'($random(seed)));
        access(MDAP_OP_RMW, pool[2], ~shadow[pool[2]]);
        access(MDAP_OP_READ, pool[2], 1'b0);
        repeat (60) begin
            r = $random(seed);
            access(mdap_op_type'(r[1:0] == 2'b11 ? 2'b00 : r[1:0]), pool[r[7:4] % 12], r[8]);
        end
        access(MDAP_OP_SELF, 16'h0000, 1'b0);
        repeat (40) @(posedge clk_sys);
        #1 self_exit = 1'b1;
        wait_ready();
        #1 self_exit = 1'b0;
        check_bit("self refresh pin", 1'b1, saw_self);
        foreach (pool[i]) access(MDAP_OP_READ, pool[i], 1'b0);
        // only refresh cycles may mark rows from here on
        foreach (rows_seen[i]) rows_seen[i] = 1'b0;
        repeat (128 * SLOT + 40) @(posedge clk_sys);
        foreach (rows_seen[i]) check_bit("refreshed row", 1'b1, rows_seen[i]);
        complete_run();
    end
endmodule : mdap_host_tb_top
`default_nettype wire
